// ---- tcmo_pkg.sv ----
// Shared constants, types and register map of the timer compare match output unit
package tcmo_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int TCMO_CNT_W = 16;
  localparam int TCMO_NTMR = 3;
  localparam int TCMO_AW = 3;
  localparam int TCMO_DW = 16;

  // ----------------------------------------------------------------
  // Register indices on the plain port
  // ----------------------------------------------------------------
  localparam logic [TCMO_AW-1:0] TCMO_ADDR_CTRL = 3'h0;
  localparam logic [TCMO_AW-1:0] TCMO_ADDR_VALUE = 3'h1;
  localparam logic [TCMO_AW-1:0] TCMO_ADDR_TSEL = 3'h2;
  localparam logic [TCMO_AW-1:0] TCMO_ADDR_STATUS = 3'h3;
  localparam logic [TCMO_AW-1:0] TCMO_ADDR_MASK = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCMO_CTRL_MODE_LSB = 0;
  localparam int TCMO_CTRL_OUT_BIT = 5;
  localparam int TCMO_CTRL_EN_BIT = 7;
  localparam int TCMO_TSEL_SEL_LSB = 0;
  localparam int TCMO_TSEL_TRIG_BIT = 4;
  localparam int TCMO_ST_MATCH_BIT = 0;
  localparam int TCMO_ST_TRIG_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] TCMO_RST_MODE = 4'h0;
  localparam logic [TCMO_CNT_W-1:0] TCMO_RST_VALUE = 16'h0000;
  localparam logic [1:0] TCMO_RST_TSEL = 2'h0;
  localparam logic [1:0] TCMO_RST_STATUS = 2'h0;
  localparam logic [1:0] TCMO_RST_MASK = 2'h0;

  // ----------------------------------------------------------------
  // Compare action codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TCMO_MODE_OFF = 4'h0,
    TCMO_MODE_TOGGLE = 4'h2,
    TCMO_MODE_SET = 4'h8,
    TCMO_MODE_CLEAR = 4'h9,
    TCMO_MODE_SWIRQ = 4'ha,
    TCMO_MODE_TRIG = 4'hb
  } tcmo_mode_t;

  // Timer reset sequencer
  typedef enum logic [0:0] {
    TCMO_IDLE = 1'b0,
    TCMO_ARMED = 1'b1
  } tcmo_arm_t;

  // Register port request
  typedef struct packed {
    logic [TCMO_AW-1:0] addr;
    logic [TCMO_DW-1:0] wdata;
    logic wr;
    logic rd;
  } tcmo_bus_req_t;

  // Timer side inputs
  typedef struct packed {
    logic [TCMO_NTMR-1:0][TCMO_CNT_W-1:0] count;
    logic [TCMO_NTMR-1:0] runs_in_sleep;
  } tcmo_timer_in_t;

  // Whole state of the unit
  typedef struct packed {
    logic en;
    logic [3:0] mode;
    logic out;
    logic [TCMO_CNT_W-1:0] value;
    logic [1:0] tsel;
    logic trig_src;
    logic [1:0] status;
    logic [1:0] mask;
    logic eq_d;
    tcmo_arm_t arm;
    logic adc_trig;
    logic tmr_reset;
    logic [TCMO_DW-1:0] rdata;
  } tcmo_state_t;

endpackage

// ---- tcmo_match_det.sv ----
// Equality detector between the compare value and the selected timer count
`timescale 1ns/100ps
module tcmo_match_det #(
  parameter int NTMR = 3,
  parameter int CW = 16
) (
  input wire logic [NTMR-1:0][CW-1:0] count,
  input wire logic [1:0] sel,
  input wire logic [CW-1:0] value,
  output logic eq
);

  logic [NTMR-1:0] eq_vec;

  // ----------------------------------------------------------------
  // Size check
  // ----------------------------------------------------------------
  if (NTMR < 1 || NTMR > 4) begin : g_chk
    $error("tcmo_match_det: NTMR must be 1 to 4");
  end

  // One comparator per timer
  for (genvar i = 0; i < NTMR; i++) begin : g_cmp
    assign eq_vec[i] = (count[i] == value);
  end

  // Selected comparator, out of range selects never match
  always_comb begin
    eq = 1'b0;
    if (32'(sel) < NTMR) begin
      eq = eq_vec[sel];
    end
  end

endmodule

// ---- tcmo_compare.sv ----
// Compare mode logic: match detection, output latch, flags, trigger and wake
`timescale 1ns/100ps

// Operation
// - Compare 16-bit value continuously with count of one of three timers.
// - On match, toggle, set or clear output, trigger, or interrupt only.
// - Every compare match sets the match flag with the output action.
// - Writing zero to the control register forces the output latch low.
// - Match with this unit selected as trigger source pulses converter trigger.
// - Changing compare value between trigger and timer reset cancels the reset.
// - In sleep, matches count only while the selected timer keeps running.
// - Flag set in sleep with interrupt enabled raises a wake request.
module tcmo_compare #(
  parameter int NTMR = tcmo_pkg::TCMO_NTMR,
  parameter int CW = tcmo_pkg::TCMO_CNT_W
) (
  input wire logic mclk,
  input wire logic srst,
  input tcmo_pkg::tcmo_bus_req_t bus_req,
  output logic [tcmo_pkg::TCMO_DW-1:0] bus_rdata,
  input tcmo_pkg::tcmo_timer_in_t timer_in,
  input wire logic sleep,
  output logic compare_output_pin,
  output logic adc_trigger,
  output logic timer_reset_req,
  output logic irq,
  output logic wake_req
);
  import tcmo_pkg::*;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (NTMR != TCMO_NTMR || CW != TCMO_CNT_W) begin : g_chk
    $error("tcmo_compare: timer count and width must match the package");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Write strobe aimed at one register
  function automatic logic wr_hit(tcmo_bus_req_t r, logic [TCMO_AW-1:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Mode code that performs a compare action
  function automatic logic is_cmp_mode(logic [3:0] m);
    logic ok;
    ok = 1'b0;
    case (m)
      TCMO_MODE_TOGGLE,
      TCMO_MODE_SET,
      TCMO_MODE_CLEAR,
      TCMO_MODE_SWIRQ,
      TCMO_MODE_TRIG: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // State and decode signals
  // ----------------------------------------------------------------
  tcmo_state_t st;
  tcmo_state_t next_st;
  logic eq;
  logic tmr_runs;
  logic match_ev;
  logic wr_ctrl;
  logic wr_value;
  logic wr_tsel;
  logic wr_status;
  logic wr_mask;
  logic ctrl_zero;
  logic [1:0] st_set;
  logic [1:0] st_clr;

  // Equality of value and selected count
  tcmo_match_det #(
    .NTMR(NTMR),
    .CW(CW)
  ) u_match (
    .count(timer_in.count),
    .sel(st.tsel),
    .value(st.value),
    .eq(eq)
  );

  // Selected timer keeps counting in sleep
  always_comb begin
    tmr_runs = 1'b0;
    if (32'(st.tsel) < NTMR) begin
      tmr_runs = timer_in.runs_in_sleep[st.tsel];
    end
  end

  // Strobe decode
  assign wr_ctrl = wr_hit(bus_req, TCMO_ADDR_CTRL);
  assign wr_value = wr_hit(bus_req, TCMO_ADDR_VALUE);
  assign wr_tsel = wr_hit(bus_req, TCMO_ADDR_TSEL);
  assign wr_status = wr_hit(bus_req, TCMO_ADDR_STATUS);
  assign wr_mask = wr_hit(bus_req, TCMO_ADDR_MASK);
  assign ctrl_zero = wr_ctrl && (bus_req.wdata == '0);

  // Rising edge of equality, blocked in sleep when timer is halted
  assign match_ev = st.en && is_cmp_mode(st.mode) && eq && !st.eq_d
    && !(sleep && !tmr_runs);

  // Sticky event sources and software clears
  assign st_set[TCMO_ST_MATCH_BIT] = match_ev;
  assign st_set[TCMO_ST_TRIG_BIT] = match_ev && st.trig_src;
  assign st_clr = wr_status ? bus_req.wdata[1:0] : 2'h0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.eq_d = eq;
    next_st.adc_trig = 1'b0;
    next_st.tmr_reset = 1'b0;
    next_st.rdata = '0;

    // Compare action on the output latch
    if (match_ev) begin
      case (st.mode)
        TCMO_MODE_TOGGLE: begin
          next_st.out = !st.out;
        end
        TCMO_MODE_SET: begin
          next_st.out = 1'b1;
        end
        TCMO_MODE_CLEAR: begin
          next_st.out = 1'b0;
        end
        default: begin
          next_st.out = st.out;
        end
      endcase
    end

    // Converter trigger when this unit is the chosen source
    if (match_ev && st.trig_src) begin
      next_st.adc_trig = 1'b1;
    end

    // Timer reset follows the trigger one edge later
    case (st.arm)
      TCMO_IDLE: begin
        if (match_ev && st.mode == TCMO_MODE_TRIG) begin
          next_st.arm = TCMO_ARMED;
        end
      end
      TCMO_ARMED: begin
        next_st.arm = TCMO_IDLE;
        next_st.tmr_reset = eq && !wr_value;
      end
      default: begin
        next_st.arm = TCMO_IDLE;
      end
    endcase

    // Register writes
    if (wr_ctrl) begin
      next_st.en = bus_req.wdata[TCMO_CTRL_EN_BIT];
      next_st.mode = bus_req.wdata[TCMO_CTRL_MODE_LSB +: 4];
    end
    if (ctrl_zero) begin
      next_st.out = 1'b0;
    end
    if (wr_value) begin
      next_st.value = bus_req.wdata[CW-1:0];
    end
    if (wr_tsel) begin
      next_st.tsel = bus_req.wdata[TCMO_TSEL_SEL_LSB +: 2];
      next_st.trig_src = bus_req.wdata[TCMO_TSEL_TRIG_BIT];
    end
    if (wr_mask) begin
      next_st.mask = bus_req.wdata[1:0];
    end

    // Write one to clear, a new event wins
    next_st.status = (st.status & ~st_clr) | st_set;

    // Read data, valid in the cycle after the strobe only
    if (bus_req.rd) begin
      case (bus_req.addr)
        TCMO_ADDR_CTRL: begin
          next_st.rdata[TCMO_CTRL_EN_BIT] = st.en;
          next_st.rdata[TCMO_CTRL_OUT_BIT] = st.out;
          next_st.rdata[TCMO_CTRL_MODE_LSB +: 4] = st.mode;
        end
        TCMO_ADDR_VALUE: begin
          next_st.rdata[CW-1:0] = st.value;
        end
        TCMO_ADDR_TSEL: begin
          next_st.rdata[TCMO_TSEL_SEL_LSB +: 2] = st.tsel;
          next_st.rdata[TCMO_TSEL_TRIG_BIT] = st.trig_src;
        end
        TCMO_ADDR_STATUS: begin
          next_st.rdata[1:0] = st.status;
        end
        TCMO_ADDR_MASK: begin
          next_st.rdata[1:0] = st.mask;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      st.en <= 1'b0;
      st.mode <= TCMO_RST_MODE;
      st.out <= 1'b0;
      st.value <= TCMO_RST_VALUE;
      st.tsel <= TCMO_RST_TSEL;
      st.trig_src <= 1'b0;
      st.status <= TCMO_RST_STATUS;
      st.mask <= TCMO_RST_MASK;
      st.eq_d <= 1'b1;
      st.arm <= TCMO_IDLE;
      st.adc_trig <= 1'b0;
      st.tmr_reset <= 1'b0;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign compare_output_pin = st.out;
  assign adc_trigger = st.adc_trig;
  assign timer_reset_req = st.tmr_reset;
  assign bus_rdata = st.rdata;
  assign irq = |(st.status & st.mask);

  // Wake when the flag is pending, enabled and the timer still counts
  assign wake_req = sleep && tmr_runs
    && st.status[TCMO_ST_MATCH_BIT] && st.mask[TCMO_ST_MATCH_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic [CW-1:0] sel_count;
  assign sel_count = (32'(st.tsel) < NTMR) ? timer_in.count[st.tsel] : ~st.value;

  // Trigger taken on a match in trigger mode
  sequence s_trig_taken;
    match_ev && st.mode == TCMO_MODE_TRIG;
  endsequence

  // Value rewritten in the cycle after the trigger
  sequence s_value_moved;
    s_trig_taken ##1 wr_value;
  endsequence

  // Value kept and match still present
  sequence s_value_kept;
    s_trig_taken ##1 (!wr_value && eq);
  endsequence

  a_equal_detect: assert property (
    eq == (sel_count == st.value))
    else $error("equality does not follow the selected count");

  a_set_action: assert property (
    match_ev && st.mode == TCMO_MODE_SET && !ctrl_zero |=> compare_output_pin)
    else $error("set action did not raise the output");

  a_clear_action: assert property (
    match_ev && st.mode == TCMO_MODE_CLEAR |=> !compare_output_pin)
    else $error("clear action did not lower the output");

  a_toggle_action: assert property (
    match_ev && st.mode == TCMO_MODE_TOGGLE && !ctrl_zero
    |=> compare_output_pin != $past(compare_output_pin))
    else $error("toggle action did not invert the output");

  a_flag_on_match: assert property (
    match_ev |=> st.status[TCMO_ST_MATCH_BIT] ##1 ($stable(st.status) || $past(wr_status)))
    else $error("match flag not set with the action");

  a_ctrl_zero_low: assert property (
    ctrl_zero |=> !compare_output_pin [*1] ##0 st.mode == TCMO_MODE_OFF)
    else $error("zero control write left the output high");

  a_trig_pulse: assert property (
    match_ev && st.trig_src |=> adc_trigger ##1 !adc_trigger)
    else $error("converter trigger is not a one cycle pulse");

  a_no_stray_trig: assert property (
    !(match_ev && st.trig_src) |=> !adc_trigger)
    else $error("converter trigger without a selected match");

  a_reset_cancel: assert property (
    s_value_moved |=> !timer_reset_req)
    else $error("timer reset happened after the value changed");

  a_reset_done: assert property (
    s_value_kept |=> timer_reset_req ##1 !timer_reset_req)
    else $error("timer reset missing after trigger");

  a_sleep_halt: assert property (
    sleep && !tmr_runs |-> !match_ev ##1 !adc_trigger)
    else $error("match taken in sleep while the timer is halted");

  a_wake_req: assert property (
    sleep && tmr_runs && match_ev ##1 sleep && tmr_runs && st.mask[TCMO_ST_MATCH_BIT]
    |-> wake_req)
    else $error("no wake request for an enabled match in sleep");

  a_reset_low: assert property (
    @(posedge mclk) disable iff (1'b0) srst |=> !compare_output_pin && !adc_trigger)
    else $error("output latch not low after reset");

endmodule

// ---- tcmo_timer_model.sv ----
// Far side model: three synchronous timers that load on request, the one picked by sel clearing on a reset pulse
`timescale 1ns/100ps
module tcmo_timer_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic load,
  input wire logic [1:0] load_idx,
  input wire logic [15:0] load_val,
  input wire logic [1:0] sel,
  input wire logic [2:0] sleep_run,
  input wire logic timer_reset_req,
  output tcmo_pkg::tcmo_timer_in_t timer_in
);
  import tcmo_pkg::*;

  logic [TCMO_NTMR-1:0][TCMO_CNT_W-1:0] cnt;

  // ----------------------------------------------------------------
  // Timer registers
  // ----------------------------------------------------------------
  // Held on mclk, no prescaler, so a count is never seen half-changed
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt <= '0;
    end else begin
      for (int i = 0; i < TCMO_NTMR; i++) begin
        if (load && load_idx == i[1:0]) cnt[i] <= load_val;
        else if (timer_reset_req && sel == i[1:0]) cnt[i] <= '0;
      end
    end
  end

  // Counts and sleep capability out to the unit
  assign timer_in.count = cnt;
  assign timer_in.runs_in_sleep = sleep_run;
endmodule

// ---- timer_compare_match_output_bench.sv ----
// Self-checking bench of the compare match output unit
`timescale 1ns/100ps
module timer_compare_match_output_bench;
  import tcmo_pkg::*;

  typedef struct packed {
    logic [1:0] tsel;
    logic [3:0] mode;
    logic trig;
    logic pin;
    logic flag;
  } tcmo_row_t;

  localparam logic [15:0] CMP_VAL = 16'h1234;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic sleep = 1'b0;
  logic load = 1'b0;
  logic [1:0] load_idx = 2'h0;
  logic [15:0] load_val = 16'h0000;
  logic [1:0] sel = 2'h0;
  logic [2:0] sleep_run = 3'h0;
  tcmo_bus_req_t bus_req = '0;
  tcmo_timer_in_t timer_in;
  logic [15:0] bus_rdata, rd_val;
  logic pin, adc_trigger, timer_reset_req, irq, wake_req;
  int num_errors = 0;
  int num_checks = 0;
  int n_adc = 0;
  int n_trs = 0;
  int cycles = 0;
  int a0, t0;
  tcmo_row_t rows [9];

  // ----------------------------------------------------------------
  // Design and far side
  // ----------------------------------------------------------------
  // Compare output wired straight to its pin as a driven output
  tcmo_compare i_dut (.mclk(mclk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .timer_in(timer_in), .sleep(sleep), .compare_output_pin(pin), .adc_trigger(adc_trigger),
    .timer_reset_req(timer_reset_req), .irq(irq), .wake_req(wake_req));
  tcmo_timer_model i_tmr (.mclk(mclk), .srst(srst), .load(load), .load_idx(load_idx),
    .load_val(load_val), .sel(sel), .sleep_run(sleep_run),
    .timer_reset_req(timer_reset_req), .timer_in(timer_in));

  // Clock, 4 ns period
  initial begin
    forever #2 mclk = ~mclk;
  end

  // Pulse counters and hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (adc_trigger === 1'b1) n_adc <= n_adc + 1;
    if (timer_reset_req === 1'b1) n_trs <= n_trs + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    #1 rd_val = bus_rdata;
  endtask

  task automatic set_count(input logic [1:0] idx, input logic [15:0] v);
    @(posedge mclk);
    load <= 1'b1;
    load_idx <= idx;
    load_val <= v;
    @(posedge mclk);
    load <= 1'b0;
  endtask

  // Leave equality, then return to it for one fresh match
  task automatic hit(input logic [1:0] idx);
    set_count(idx, ~CMP_VAL);
    set_count(idx, CMP_VAL);
    repeat (3) @(posedge mclk);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    #1;
    check({13'h0, irq, wake_req, pin}, 16'h0000);
    rd(TCMO_ADDR_CTRL);
    check(rd_val, 16'h0000);
    rd(TCMO_ADDR_STATUS);
    check(rd_val, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rows = '{'{2'h0, TCMO_MODE_SET, 1'b1, 1'b1, 1'b1}, '{2'h1, TCMO_MODE_TOGGLE, 1'b0, 1'b0, 1'b1},
      '{2'h2, TCMO_MODE_TOGGLE, 1'b1, 1'b1, 1'b1}, '{2'h0, TCMO_MODE_CLEAR, 1'b0, 1'b0, 1'b1},
      '{2'h1, TCMO_MODE_SWIRQ, 1'b1, 1'b0, 1'b1}, '{2'h2, TCMO_MODE_TRIG, 1'b1, 1'b0, 1'b1},
      '{2'h0, TCMO_MODE_OFF, 1'b1, 1'b0, 1'b0}, '{2'h0, 4'h3, 1'b1, 1'b0, 1'b0},
      '{2'h3, TCMO_MODE_SET, 1'b1, 1'b0, 1'b0}};
    do_reset();
    wr(TCMO_ADDR_VALUE, CMP_VAL);
    rd(TCMO_ADDR_VALUE);
    check(rd_val, CMP_VAL);
    // Every action code spread over timers 0 to 2, toggle on timers 1 and 2, plus off, code 3 and select 3
    foreach (rows[i]) begin
      sel <= rows[i].tsel;
      wr(TCMO_ADDR_TSEL, {11'h0, rows[i].trig, 2'h0, rows[i].tsel});
      wr(TCMO_ADDR_CTRL, {8'h00, 4'h8, rows[i].mode});
      wr(TCMO_ADDR_STATUS, 16'h0003);
      a0 = n_adc;
      t0 = n_trs;
      hit(rows[i].tsel == 2'h3 ? 2'h0 : rows[i].tsel);
      rd(TCMO_ADDR_STATUS);
      check({15'h0, pin}, {15'h0, rows[i].pin});
      check({15'h0, rd_val[0]}, {15'h0, rows[i].flag});
      check(16'(n_adc - a0), {15'h0, rows[i].flag & rows[i].trig});
      check(16'(n_trs - t0), {15'h0, rows[i].flag && rows[i].mode == TCMO_MODE_TRIG});
    end
    // Value change right after the trigger cancels the timer reset
    // Count moved off the value first, so the select change makes no stray match
    sel <= 2'h0;
    set_count(2'h0, ~CMP_VAL);
    wr(TCMO_ADDR_CTRL, {8'h00, 4'h8, TCMO_MODE_TRIG});
    wr(TCMO_ADDR_TSEL, 16'h0010);
    a0 = n_adc;
    t0 = n_trs;
    set_count(2'h0, CMP_VAL);
    wr(TCMO_ADDR_VALUE, CMP_VAL + 16'h0001);
    repeat (3) @(posedge mclk);
    check(16'(n_adc - a0), 16'h0001);
    check(16'(n_trs - t0), 16'h0000);
    wr(TCMO_ADDR_VALUE, CMP_VAL);
    // Held equality, sticky flag, mask and clear
    wr(TCMO_ADDR_CTRL, {8'h00, 4'h8, TCMO_MODE_SET});
    wr(TCMO_ADDR_STATUS, 16'h0003);
    wr(TCMO_ADDR_MASK, 16'h0001);
    hit(2'h0);
    check({15'h0, irq}, 16'h0001);
    repeat (20) @(posedge mclk);
    rd(TCMO_ADDR_STATUS);
    check({15'h0, rd_val[0]}, 16'h0001);
    wr(TCMO_ADDR_STATUS, 16'h0001);
    rd(TCMO_ADDR_STATUS);
    check({15'h0, rd_val[0]}, 16'h0000);
    check({15'h0, irq}, 16'h0000);
    wr(TCMO_ADDR_MASK, 16'h0000);
    hit(2'h0);
    check({15'h0, irq}, 16'h0000);
    wr(TCMO_ADDR_MASK, 16'h0001);
    #1;
    check({15'h0, irq}, 16'h0001);
    wr(TCMO_ADDR_STATUS, 16'h0001);
    #1;
    check({15'h0, irq}, 16'h0000);
    // Zero control write drops the latch
    check({15'h0, pin}, 16'h0001);
    wr(TCMO_ADDR_CTRL, 16'h0000);
    #1;
    check({15'h0, pin}, 16'h0000);
    // Sleep with stopped and with running timer
    wr(TCMO_ADDR_CTRL, {8'h00, 4'h8, TCMO_MODE_SWIRQ});
    @(posedge mclk);
    sleep <= 1'b1;
    hit(2'h0);
    rd(TCMO_ADDR_STATUS);
    check({15'h0, rd_val[0]}, 16'h0000);
    check({15'h0, wake_req}, 16'h0000);
    @(posedge mclk);
    sleep_run <= 3'h1;
    hit(2'h0);
    check({15'h0, wake_req}, 16'h0001);
    @(posedge mclk);
    sleep <= 1'b0;
    #1;
    check({15'h0, wake_req}, 16'h0000);
    rd(3'h7);
    check(rd_val, 16'h0000);
    // Mid-run reset with the latch high
    wr(TCMO_ADDR_CTRL, {8'h00, 4'h8, TCMO_MODE_SET});
    hit(2'h0);
    check({15'h0, pin}, 16'h0001);
    do_reset();
    final_report();
  end
endmodule
